// ---- core/scrx_channel.sv ----
// serial channel receive and transmit datapath: uart and clocked modes, buffers and fifos
// assumes serial_sample_clock is a one-cycle pulse from an outside baud generator on clk_sys
`timescale 1ns/1ps
`include "scrx_cfg.svh"

module scrx_channel #(
  parameter int RX_FIFO_DEPTH = `SCRX_FIFO_DEPTH,
  parameter int TX_FIFO_DEPTH = `SCRX_FIFO_DEPTH
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic                    serial_sample_clock,
  input  wire logic [`SCRX_ADDR_W-1:0] reg_addr,
  input  wire logic [`SCRX_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`SCRX_DATA_W-1:0] reg_rdata,
  input  wire logic                    receive_data_pin,
  output logic                         transmit_data_pin,
  input  wire logic                    serial_clock_pin_i,
  output logic                         serial_clock_pin_o,
  output logic                         serial_clock_pin_oe,
  output logic                         receive_interrupt,
  output logic                         transmit_interrupt
);
  localparam int LW = 3;
  if (RX_FIFO_DEPTH < 2 || RX_FIFO_DEPTH > 7 || TX_FIFO_DEPTH < 2 || TX_FIFO_DEPTH > 7) begin : g_bad_depth
    $error("fifo depth out of range");
  end

  scrx_pkg::scrx_cfg_t   cfg_reg;
  scrx_pkg::scrx_state_t rx_st_reg;
  scrx_pkg::scrx_frame_t rx_buf_reg;
  scrx_pkg::scrx_frame_t rx_hold_reg;
  logic                  rxe_reg;
  logic                  txe_reg;
  logic                  oerr_reg;
  logic                  perr_reg;
  logic                  ferr_reg;
  logic                  rb8_reg;
  logic                  rx_full_reg;
  logic                  rx_held_reg;
  logic [3:0]            rx_os_reg;
  logic [3:0]            rx_bit_reg;
  logic [8:0]            rx_sh_reg;
  logic [7:0]            rf_mem_reg [RX_FIFO_DEPTH];
  logic [LW-1:0]         rf_lvl_reg;
  logic [7:0]            tb_data_reg;
  logic                  tb_full_reg;
  logic                  tx_buffer_empty_flag_reg;
  logic [7:0]            tf_mem_reg [TX_FIFO_DEPTH];
  logic [LW-1:0]         tf_lvl_reg;
  logic                  tx_busy_reg;
  logic [3:0]            tx_os_reg;
  logic [3:0]            tx_cnt_reg;
  logic [10:0]           tx_sh_reg;
  logic                  txd_reg;
  logic                  sclk_reg;
  logic                  sck_s1_reg;
  logic                  sck_s2_reg;
  logic                  sck_s3_reg;
  logic [`SCRX_DATA_W-1:0] rdata_reg;
  logic                  rx_int_reg;
  logic                  tx_int_reg;
  logic                  rxd_sync;
  logic                  rxd_filt;

  scrx_rx_filter #(.LEN(`SCRX_FILT_LEN)) u_filter (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .sample_tick (serial_sample_clock),
    .pin_async   (receive_data_pin),
    .pin_sync    (rxd_sync),
    .level       (rxd_filt)
  );

  // mode decode
  wire tick      = serial_sample_clock;
  wire uart      = cfg_reg.uart;
  wire drv       = !uart && !cfg_reg.clk_in;
  wire rx_dbl    = cfg_reg.dbl || !drv;
  wire nine_bits = cfg_reg.nine || cfg_reg.par_en;
  wire rf_en     = cfg_reg.fifo_en && cfg_reg.dbl && (cfg_reg.dpx == `SCRX_DPX_RX || cfg_reg.dpx == `SCRX_DPX_FULL);
  wire tf_en     = cfg_reg.fifo_en && cfg_reg.dbl && (cfg_reg.dpx == `SCRX_DPX_TX || cfg_reg.dpx == `SCRX_DPX_FULL);
  wire [LW-1:0] rf_cap = (cfg_reg.dpx == `SCRX_DPX_FULL) ? `SCRX_FULL_CAP : LW'(RX_FIFO_DEPTH);
  wire [LW-1:0] tf_cap = (cfg_reg.dpx == `SCRX_DPX_FULL) ? `SCRX_FULL_CAP : LW'(TX_FIFO_DEPTH);

  // register port decode
  wire wr_buf   = reg_wr && reg_addr == `SCRX_OFF_BUF;
  wire wr_ctrl  = reg_wr && reg_addr == `SCRX_OFF_CTRL;
  wire wr_mode0 = reg_wr && reg_addr == `SCRX_OFF_MODE0;
  wire wr_mode2 = reg_wr && reg_addr == `SCRX_OFF_MODE2;
  wire wr_fcnf  = reg_wr && reg_addr == `SCRX_OFF_FCNF;
  wire rd_buf   = reg_rd && reg_addr == `SCRX_OFF_BUF;
  wire rd_ctrl  = reg_rd && reg_addr == `SCRX_OFF_CTRL;

  // serial clock edges, own or from the pin
  wire rx_stop   = drv && (rx_dbl ? rx_held_reg : rx_full_reg);
  wire sclk_run  = (rxe_reg && !rx_stop) || (tx_busy_reg && txe_reg) || !sclk_reg;
  wire int_step  = drv && tick && sclk_run;
  wire int_rise  = int_step && !sclk_reg;
  wire int_fall  = int_step && sclk_reg;
  wire ext_rise  = !uart && !drv && sck_s2_reg && !sck_s3_reg;
  wire ext_fall  = !uart && !drv && !sck_s2_reg && sck_s3_reg;
  wire samp_edge = drv ? int_rise : (cfg_reg.edge_sel ? ext_fall : ext_rise);
  wire drv_edge  = drv ? int_fall : (cfg_reg.edge_sel ? ext_rise : ext_fall);

  // receive frame assembly
  wire       rx_in      = uart ? rxd_filt : rxd_sync;
  wire [8:0] rx_sh_in   = {rx_in, rx_sh_reg[8:1]};
  wire [3:0] rx_last    = nine_bits ? `SCRX_RX_LAST9 : `SCRX_RX_LAST8;
  wire       rx_mid     = uart && tick && rx_st_reg == scrx_pkg::SCRX_BUSY && rx_os_reg == `SCRX_OS_SAMPLE;
  wire       io_samp    = !uart && samp_edge && rxe_reg && !rx_stop;
  wire       rx_done    = rxe_reg && ((rx_mid && rx_bit_reg == rx_last) || (io_samp && rx_bit_reg == `SCRX_IO_LAST));
  wire [8:0] rx_word    = uart ? rx_sh_reg : rx_sh_in;
  wire       wide       = uart && nine_bits;
  scrx_pkg::scrx_frame_t rx_frame;
  assign rx_frame.data  = wide ? rx_word[7:0] : rx_word[8:1];
  assign rx_frame.ninth = wide && rx_word[8];
  wire par_bad  = uart && cfg_reg.par_en && !cfg_reg.nine && ((^rx_word) ~^ cfg_reg.par_even);
  wire fr_bad   = uart && !rxd_filt;

  // receive buffer and fifo movement
  wire          rf_pop       = rd_buf && rf_en && rf_lvl_reg != '0;
  wire          buf_rd       = rd_buf && !rf_pop;
  wire          rf_room      = rf_lvl_reg != rf_cap || rf_pop;
  wire          buf_to_fifo  = rf_en && rx_full_reg && rf_room;
  wire          buf_avail    = !rx_full_reg || buf_rd || buf_to_fifo;
  wire          hold_to_buf  = rx_held_reg && buf_avail;
  wire          frame_to_buf = rx_done && buf_avail && !rx_held_reg;
  wire          hold_ok      = (rf_en && cfg_reg.astop) || (drv && rx_dbl);
  wire          frame_hold   = rx_done && !buf_avail && !rx_held_reg && hold_ok;
  wire          overrun      = rx_done && !buf_avail && !hold_ok;
  wire          buf_load     = hold_to_buf || frame_to_buf;
  wire          auto_clr     = frame_hold && rf_en && cfg_reg.astop;
  scrx_pkg::scrx_frame_t buf_in;
  assign buf_in = hold_to_buf ? rx_hold_reg : rx_frame;
  wire [LW-1:0] rf_wr_idx    = LW'(rf_lvl_reg - {{(LW-1){1'b0}}, rf_pop});
  wire [LW-1:0] rf_lvl_next  = LW'(rf_wr_idx + {{(LW-1){1'b0}}, buf_to_fifo});
  wire [LW-1:0] ril_n        = (cfg_reg.ril == 2'h0) ? `SCRX_RIL_ZERO : {1'b0, cfg_reg.ril};
  wire          rf_hit       = cfg_reg.rge ? rf_lvl_next >= ril_n : rf_lvl_next == ril_n;
  wire          wake_ok      = !(uart && cfg_reg.nine && cfg_reg.wake) || buf_in.ninth;
  wire          rx_int       = rf_en ? ((buf_to_fifo || rf_pop) && rf_hit) : (buf_load && wake_ok);
  wire [7:0]    rd_data      = rf_pop ? rf_mem_reg[0] : rx_buf_reg.data;

  // transmit buffer, fifo and shifter
  wire          tx_bitclk   = uart && tick && tx_os_reg == `SCRX_OS_LAST;
  wire          tx_step     = tx_busy_reg && txe_reg && (uart ? tx_bitclk : drv_edge);
  wire [3:0]    tx_len      = !uart ? `SCRX_IO_BITS : (nine_bits ? `SCRX_TX_LEN9 : `SCRX_TX_LEN8);
  wire          tx_done     = tx_busy_reg && txe_reg && tx_cnt_reg == tx_len && (uart ? tx_bitclk : samp_edge);
  wire          tx_free     = !tx_busy_reg || tx_done;
  wire          tb_move     = cfg_reg.dbl && tb_full_reg && tx_free && txe_reg;
  wire          tb_refill   = tf_en && (!tb_full_reg || tb_move) && tf_lvl_reg != '0;
  wire          wr_to_tb    = wr_buf && cfg_reg.dbl && (!tb_full_reg || tb_move) && !tb_refill;
  wire          wr_to_tf    = wr_buf && tf_en && !wr_to_tb && (tf_lvl_reg != tf_cap || tb_refill);
  wire          wr_to_sh    = wr_buf && !cfg_reg.dbl && tx_free;
  wire          sh_load     = tb_move || wr_to_sh;
  wire [7:0]    sh_data     = wr_to_sh ? reg_wdata[7:0] : tb_data_reg;
  wire          tx_ninth    = cfg_reg.nine ? cfg_reg.tb8 : ((^sh_data) ~^ cfg_reg.par_even);
  wire [10:0]   sh_frame    = !uart ? {3'h7, sh_data} : (nine_bits ? {1'b1, tx_ninth, sh_data, 1'b0}
                                                                   : {2'h3, sh_data, 1'b0});
  wire [LW-1:0] tf_wr_idx   = LW'(tf_lvl_reg - {{(LW-1){1'b0}}, tb_refill});
  wire          tx_int      = cfg_reg.dbl ? tb_move : tx_done;

  // register read words, declared ahead of the read data flop that samples them
  wire [`SCRX_DATA_W-1:0] ctrl_word = {23'h0, cfg_reg.tb8, rb8_reg, cfg_reg.par_even, cfg_reg.par_en,
                                       oerr_reg, perr_reg, ferr_reg, cfg_reg.clk_in, cfg_reg.edge_sel};
  wire [`SCRX_DATA_W-1:0] mode0_word = {27'h0, txe_reg, rxe_reg, cfg_reg.wake, cfg_reg.nine, cfg_reg.uart};
  wire [`SCRX_DATA_W-1:0] mode2_word = {29'h0, tx_buffer_empty_flag_reg, rx_full_reg, cfg_reg.dbl};
  wire [`SCRX_DATA_W-1:0] fcnf_word  = {25'h0, cfg_reg.rge, cfg_reg.ril, cfg_reg.dpx, cfg_reg.astop, cfg_reg.fifo_en};
  wire [`SCRX_DATA_W-1:0] stat_word  = {22'h0, tx_busy_reg, rx_st_reg == scrx_pkg::SCRX_BUSY, 1'b0, tf_lvl_reg,
                                        1'b0, rf_lvl_reg};
  wire [`SCRX_DATA_W-1:0] rd_word    = (reg_addr == `SCRX_OFF_BUF)   ? {24'h0, rd_data} :
                                       (reg_addr == `SCRX_OFF_CTRL)  ? ctrl_word :
                                       (reg_addr == `SCRX_OFF_MODE0) ? mode0_word :
                                       (reg_addr == `SCRX_OFF_MODE2) ? mode2_word :
                                       (reg_addr == `SCRX_OFF_FCNF)  ? fcnf_word :
                                       (reg_addr == `SCRX_OFF_STAT)  ? stat_word : '0;

  // control, mode and error registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_reg  <= '0;
      rxe_reg  <= 1'b0;
      txe_reg  <= 1'b0;
      oerr_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        cfg_reg.edge_sel <= reg_wdata[`SCRX_CR_EDGE];
        cfg_reg.clk_in   <= reg_wdata[`SCRX_CR_DIR];
        cfg_reg.par_en   <= reg_wdata[`SCRX_CR_PEN];
        cfg_reg.par_even <= reg_wdata[`SCRX_CR_PEVEN];
        cfg_reg.tb8      <= reg_wdata[`SCRX_CR_TB8];
      end
      if (wr_mode0) begin
        cfg_reg.uart <= reg_wdata[`SCRX_M0_UART];
        cfg_reg.nine <= reg_wdata[`SCRX_M0_NINE];
        cfg_reg.wake <= reg_wdata[`SCRX_M0_WAKE];
        txe_reg      <= reg_wdata[`SCRX_M0_TXE];
      end
      if (wr_mode2) begin
        cfg_reg.dbl <= reg_wdata[`SCRX_M2_DBL];
      end
      if (wr_fcnf) begin
        cfg_reg.fifo_en <= reg_wdata[`SCRX_FC_EN];
        cfg_reg.astop   <= reg_wdata[`SCRX_FC_ASTOP];
        cfg_reg.dpx     <= reg_wdata[`SCRX_FC_DPX +: 2];
        cfg_reg.ril     <= reg_wdata[`SCRX_FC_RIL +: 2];
        cfg_reg.rge     <= reg_wdata[`SCRX_FC_RGE];
      end
      if (wr_mode0) begin
        rxe_reg <= reg_wdata[`SCRX_M0_RXE];
      end else if (auto_clr) begin
        rxe_reg <= 1'b0;
      end
      oerr_reg <= overrun || (oerr_reg && !rd_ctrl);
      perr_reg <= (rx_done && par_bad) || (perr_reg && !rd_ctrl);
      ferr_reg <= (rx_done && fr_bad) || (ferr_reg && !rd_ctrl);
    end
  end

  // receive sampling and bit counting
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_st_reg  <= scrx_pkg::SCRX_IDLE;
      rx_os_reg  <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg  <= 9'h000;
    end else if (clk_en) begin
      if (!rxe_reg) begin
        rx_st_reg  <= scrx_pkg::SCRX_IDLE;
        rx_bit_reg <= 4'h0;
      end else if (uart && tick) begin
        unique case (rx_st_reg)
          scrx_pkg::SCRX_IDLE: begin
            if (!rxd_filt) begin
              rx_st_reg  <= scrx_pkg::SCRX_BUSY;
              rx_os_reg  <= 4'h0;
              rx_bit_reg <= 4'h0;
            end
          end
          scrx_pkg::SCRX_BUSY: begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == `SCRX_OS_SAMPLE) begin
              if ((rx_bit_reg == 4'h0 && rxd_filt) || rx_bit_reg == rx_last) begin
                rx_st_reg <= scrx_pkg::SCRX_IDLE;
              end else begin
                if (rx_bit_reg != 4'h0) begin
                  rx_sh_reg <= rx_sh_in;
                end
                rx_bit_reg <= rx_bit_reg + 4'h1;
              end
            end
          end
        endcase
      end else if (io_samp) begin
        rx_sh_reg  <= rx_sh_in;
        rx_bit_reg <= (rx_bit_reg == `SCRX_IO_LAST) ? 4'h0 : rx_bit_reg + 4'h1;
      end
    end
  end

  // receive buffer, hold stage and full flag
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_buf_reg  <= '0;
      rx_hold_reg <= '0;
      rx_full_reg <= 1'b0;
      rx_held_reg <= 1'b0;
      rb8_reg     <= 1'b0;
      rf_lvl_reg  <= '0;
    end else if (clk_en) begin
      if (buf_load) begin
        rx_buf_reg <= buf_in;
        rb8_reg    <= buf_in.ninth;
      end
      rx_full_reg <= buf_load || (rx_full_reg && !buf_rd && !buf_to_fifo);
      if (frame_hold) begin
        rx_hold_reg <= rx_frame;
      end
      rx_held_reg <= frame_hold || (rx_held_reg && !hold_to_buf);
      rf_lvl_reg  <= rf_lvl_next;
    end
  end

  for (genvar i = 0; i < RX_FIFO_DEPTH; i++) begin : g_rf
    wire [7:0] shifted = (rf_pop && i + 1 < RX_FIFO_DEPTH) ? rf_mem_reg[(i + 1) % RX_FIFO_DEPTH] : rf_mem_reg[i];
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        rf_mem_reg[i] <= 8'h00;
      end else if (clk_en) begin
        rf_mem_reg[i] <= (buf_to_fifo && rf_wr_idx == LW'(i)) ? rx_buf_reg.data : shifted;
      end
    end
  end

  for (genvar i = 0; i < TX_FIFO_DEPTH; i++) begin : g_tf
    wire [7:0] shifted = (tb_refill && i + 1 < TX_FIFO_DEPTH) ? tf_mem_reg[(i + 1) % TX_FIFO_DEPTH] : tf_mem_reg[i];
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        tf_mem_reg[i] <= 8'h00;
      end else if (clk_en) begin
        tf_mem_reg[i] <= (wr_to_tf && tf_wr_idx == LW'(i)) ? reg_wdata[7:0] : shifted;
      end
    end
  end

  // transmit buffer and fifo level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tb_data_reg <= 8'h00;
      tb_full_reg <= 1'b0;
      tx_buffer_empty_flag_reg   <= `SCRX_TX_BUFFER_EMPTY_FLAG_RST;
      tf_lvl_reg  <= '0;
    end else if (clk_en) begin
      if (tb_refill) begin
        tb_data_reg <= tf_mem_reg[0];
      end else if (wr_to_tb) begin
        tb_data_reg <= reg_wdata[7:0];
      end
      tb_full_reg <= tb_refill || wr_to_tb || (tb_full_reg && !tb_move);
      tx_buffer_empty_flag_reg   <= (tx_buffer_empty_flag_reg || tb_move) && !(tb_refill || wr_to_tb);
      tf_lvl_reg  <= LW'(tf_wr_idx + {{(LW-1){1'b0}}, wr_to_tf});
    end
  end

  // transmit counter and shifter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_os_reg   <= 4'h0;
      tx_busy_reg <= 1'b0;
      tx_cnt_reg  <= 4'h0;
      tx_sh_reg   <= 11'h7FF;
      txd_reg     <= 1'b1;
    end else if (clk_en) begin
      if (uart && tick) begin
        tx_os_reg <= tx_os_reg + 4'h1;
      end
      if (sh_load) begin
        tx_busy_reg <= 1'b1;
        tx_cnt_reg  <= 4'h0;
        tx_sh_reg   <= sh_frame;
      end else if (tx_done) begin
        tx_busy_reg <= 1'b0;
      end else if (tx_step && tx_cnt_reg != tx_len) begin
        txd_reg    <= tx_sh_reg[0];
        tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end
    end
  end

  // serial clock pin, read data and interrupt pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
      sck_s3_reg <= 1'b1;
      sclk_reg   <= 1'b1;
      rdata_reg  <= '0;
      rx_int_reg <= 1'b0;
      tx_int_reg <= 1'b0;
    end else if (clk_en) begin
      sck_s1_reg <= serial_clock_pin_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      if (int_step) begin
        sclk_reg <= !sclk_reg;
      end else if (!drv) begin
        sclk_reg <= 1'b1;
      end
      if (reg_rd) begin
        rdata_reg <= rd_word;
      end
      rx_int_reg <= rx_int;
      tx_int_reg <= tx_int;
    end
  end

  assign reg_rdata           = rdata_reg;
  assign transmit_data_pin   = txd_reg;
  assign serial_clock_pin_o  = sclk_reg;
  assign serial_clock_pin_oe = drv;
  assign receive_interrupt   = rx_int_reg;
  assign transmit_interrupt  = tx_int_reg;
endmodule // scrx_channel

// ---- common/scrx_cfg.svh ----
// register offsets, field positions, reset values and timing counts of the serial channel
// assumes byte addresses on an 8-bit register port with 32-bit data
`ifndef SCRX_CFG_SVH
`define SCRX_CFG_SVH

`define SCRX_ADDR_W      8
`define SCRX_DATA_W      32

`define SCRX_OFF_BUF     8'h00
`define SCRX_OFF_CTRL    8'h04
`define SCRX_OFF_MODE0   8'h08
`define SCRX_OFF_MODE2   8'h0C
`define SCRX_OFF_FCNF    8'h10
`define SCRX_OFF_STAT    8'h14

`define SCRX_CR_EDGE     0
`define SCRX_CR_DIR      1
`define SCRX_CR_FERR     2
`define SCRX_CR_PERR     3
`define SCRX_CR_OERR     4
`define SCRX_CR_PEN      5
`define SCRX_CR_PEVEN    6
`define SCRX_CR_RB8      7
`define SCRX_CR_TB8      8

`define SCRX_M0_UART     0
`define SCRX_M0_NINE     1
`define SCRX_M0_WAKE     2
`define SCRX_M0_RXE      3
`define SCRX_M0_TXE      4

`define SCRX_M2_DBL      0
`define SCRX_M2_RBFULL   1
`define SCRX_M2_TX_BUFFER_EMPTY_FLAG    2

`define SCRX_FC_EN       0
`define SCRX_FC_ASTOP    1
`define SCRX_FC_DPX      2
`define SCRX_FC_RIL      4
`define SCRX_FC_RGE      6

`define SCRX_ST_RLVL     0
`define SCRX_ST_TLVL     4
`define SCRX_ST_RXBUSY   8
`define SCRX_ST_TXBUSY   9

`define SCRX_TX_BUFFER_EMPTY_FLAG_RST   1'b1
`define SCRX_FIFO_DEPTH  4
`define SCRX_FILT_LEN    3
`define SCRX_OS_LAST     4'hF
`define SCRX_OS_SAMPLE   4'h7
`define SCRX_RX_LAST8    4'h9
`define SCRX_RX_LAST9    4'hA
`define SCRX_TX_LEN8     4'hA
`define SCRX_TX_LEN9     4'hB
`define SCRX_IO_BITS     4'h8
`define SCRX_IO_LAST     4'h7
`define SCRX_DPX_RX      2'h1
`define SCRX_DPX_TX      2'h2
`define SCRX_DPX_FULL    2'h3
`define SCRX_FULL_CAP    3'h2
`define SCRX_RIL_ZERO    3'h4

`endif

// ---- common/scrx_pkg.sv ----
// types shared by the serial channel datapath
// assumes scrx_cfg.svh holds the numeric constants
package scrx_pkg;

  typedef enum logic {SCRX_IDLE, SCRX_BUSY} scrx_state_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } scrx_frame_t;

  typedef struct packed {
    logic       uart;
    logic       nine;
    logic       wake;
    logic       edge_sel;
    logic       clk_in;
    logic       par_en;
    logic       par_even;
    logic       tb8;
    logic       dbl;
    logic       fifo_en;
    logic       astop;
    logic [1:0] dpx;
    logic [1:0] ril;
    logic       rge;
  } scrx_cfg_t;

endpackage

// ---- core/scrx_rx_filter.sv ----
// receive line synchroniser and consecutive-match filter
// assumes sample_tick is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
`include "scrx_cfg.svh"

module scrx_rx_filter #(
  parameter int LEN = `SCRX_FILT_LEN
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic sample_tick,
  input  wire logic pin_async,
  output logic      pin_sync,
  output logic      level
);
  if (LEN < 2 || LEN > 8) begin : g_bad_len
    $error("filter length out of range");
  end

  logic           s1_reg;
  logic           s2_reg;
  logic [LEN-1:0] hist_reg;
  logic           level_reg;
  wire            all_one  = &hist_reg;
  wire            all_zero = ~|hist_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      hist_reg  <= '1;
      level_reg <= 1'b1;
    end else if (clk_en) begin
      s1_reg <= pin_async;
      s2_reg <= s1_reg;
      if (sample_tick) begin
        hist_reg <= {hist_reg[LEN-2:0], s2_reg};
        if (all_one) begin
          level_reg <= 1'b1;
        end else if (all_zero) begin
          level_reg <= 1'b0;
        end
      end
    end
  end

  assign pin_sync = s2_reg;
  assign level    = level_reg;
endmodule // scrx_rx_filter

// ---- sim/scrx_props.sv ----
// port-level checker for the serial channel
// assumes the register map of scrx_cfg.svh
`timescale 1ns/1ps
module scrx_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        serial_sample_clock,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        transmit_data_pin,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe,
  input wire logic        receive_interrupt,
  input wire logic        transmit_interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rx_pulse_a: assert property (receive_interrupt |=> !receive_interrupt) else $error("rx pulse long");
  tx_pulse_a: assert property (transmit_interrupt |=> !transmit_interrupt) else $error("tx pulse long");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h0) else $error("bad unmapped");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
  idle_lines_a: assert property ($rose(rst_n) |-> transmit_data_pin && serial_clock_pin_o) else $error("not idle");
  sclk_tick_a: assert property ($changed(serial_clock_pin_o) |-> $past(serial_sample_clock)) else $error("sclk");
  oe_uart_a: assert property (reg_wr && reg_addr == 8'h08 && reg_wdata[0] |=> !serial_clock_pin_oe) else $error("oe");
  err_clear_a: assert property ((reg_rd && reg_addr == 8'h04) ##2 (reg_rd && reg_addr == 8'h04)
    |=> reg_rdata[4:2] == 3'h0) else $error("flags kept");
  rx_int_c: cover property (receive_interrupt);
  tx_int_c: cover property (transmit_interrupt);
  ctrl_read_c: cover property (reg_rd && reg_addr == 8'h04);
endmodule // scrx_props
bind scrx_channel scrx_props u_props (.*);

// ---- sim/scrx_peer.sv ----
// far-end peer: echoes the line back and decodes each uart frame heard
// assumes tick is the 16x sample pulse, eight data bits, one stop bit
`timescale 1ns/1ps
module scrx_peer (
  input  wire logic       clk_sys,
  input  wire logic       tick,
  input  wire logic       txd,
  output logic            rxd,
  output logic      [7:0] got,
  output logic            got_v
);
  logic [7:0] cnt_reg = 8'h00;
  logic       busy_reg = 1'b0;
  logic [9:0] sh_reg;
  assign rxd = txd;
  always_ff @(posedge clk_sys) begin
    got_v <= 1'b0;
    if (tick && !busy_reg && !txd) begin
      busy_reg <= 1'b1;
      cnt_reg  <= 8'h00;
    end else if (tick && busy_reg) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg[3:0] == 4'h7) sh_reg <= {txd, sh_reg[9:1]};
      if (cnt_reg == 8'h97) begin
        busy_reg <= 1'b0;
        got      <= sh_reg[9:2];
        got_v    <= txd;
      end
    end
  end
endmodule // scrx_peer

// ---- sim/test_serial_channel_rx_tx_path.sv ----
// bench: uart frames out through the peer and back in, buffer flags, overrun, clocked loopback
// assumes scrx_channel, scrx_props and scrx_peer are compiled first
`timescale 1ns/1ps
module test_serial_channel_rx_tx_path;
  logic        clk_sys = 1'b0, rst_n = 1'b0, tick = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, g;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        txd, rxd, rxi, txi, got_v, r, t, sck;
  logic [7:0]  got;
  logic [15:0] rows [4] = '{16'h5555, 16'hA3A3, 16'h0000, 16'hFFFF};
  int          mismatches = 0, n_checks = 0, cyc = 0, i;
  scrx_channel DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .serial_sample_clock(tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .receive_data_pin(rxd), .transmit_data_pin(txd), .serial_clock_pin_i(1'b1), .serial_clock_pin_o(sck),
    .serial_clock_pin_oe(), .receive_interrupt(rxi), .transmit_interrupt(txi));
  scrx_peer peer (.clk_sys(clk_sys), .tick(tick), .txd(txd), .rxd(rxd), .got(got), .got_v(got_v));
  initial forever #12.5 clk_sys = ~clk_sys;
  // sample pulse every 200 ns
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    tick <= (cyc % 8 == 7);
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // waits for both interrupts, catching the peer's byte meanwhile
  task automatic wi(input logic er);
    r = 1'b0;
    t = 1'b0;
    for (i = 0; i < 3000 && !(r && t); i++) begin
      @(negedge clk_sys);
      r |= rxi;
      t |= txi;
      if (got_v === 1'b1) g = got;
    end
    cmp("rx interrupt", er, r);
    cmp("tx interrupt", 1'h1, t);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h0C);
    cmp("mode2 reset", 32'h4, d);
    rd(8'h18);
    cmp("unmapped", 32'h0, d);
    wr(8'h08, 32'h19);
    foreach (rows[k]) begin
      wr(8'h00, rows[k][15:8]);
      wi(1'b1);
      cmp("peer byte", rows[k][7:0], g);
      rd(8'h0C);
      cmp("rx full", 1'h1, d[1]);
      rd(8'h00);
      cmp("rx data", rows[k][7:0], d[7:0]);
      rd(8'h0C);
      cmp("rx cleared", 1'h0, d[1]);
    end
    wr(8'h00, 32'h3C);
    wi(1'b1);
    wr(8'h00, 32'hC3);
    wi(1'b0);
    rd(8'h04);
    cmp("overrun", 1'h1, d[4]);
    rd(8'h04);
    cmp("flags cleared", 3'h0, d[4:2]);
    rd(8'h00);
    cmp("kept buffer", 8'h3C, d[7:0]);
    // clocked mode, driven clock, single buffer: both enables set together so tx and rx start aligned
    wr(8'h08, 32'h0);
    wr(8'h00, 32'hA5);
    wr(8'h08, 32'h18);
    wi(1'b1);
    repeat (20) @(negedge clk_sys);
    cmp("clock parked", 1'h1, sck);
    repeat (8) @(negedge clk_sys);
    cmp("clock still parked", 1'h1, sck);
    rd(8'h00);
    cmp("io rx data", 8'hA5, d[7:0]);
    for (i = 0; i < 40 && sck; i++) @(negedge clk_sys);
    cmp("clock restarted", 1'h0, sck);
    tally_and_finish();
  end
endmodule // test_serial_channel_rx_tx_path
